// [rtl/msdspi_pkg.sv]
// constants for the motor driver serial slave port
package msdspi_pkg;

  // ***************************************************
  // command and address
  // ***************************************************
  localparam logic [2:0] MSDSPI_CMD_READ = 3'h0;
  localparam logic [2:0] MSDSPI_CMD_WRITE = 3'h4;
  localparam int MSDSPI_CMD_HI = 7;
  localparam int MSDSPI_CMD_LO = 5;
  localparam int MSDSPI_ADDR_HI = 4;
  localparam int MSDSPI_ADDR_LO = 0;

  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [4:0] MSDSPI_ADDR_STEP_CURRENT_CONFIG = 5'h01;
  localparam logic [4:0] MSDSPI_ADDR_DRIVE_CONTROL_CONFIG = 5'h02;
  localparam logic [4:0] MSDSPI_ADDR_POWER_FEEDBACK_CONFIG = 5'h03;
  localparam logic [4:0] MSDSPI_ADDR_STATUS0 = 5'h04;
  localparam logic [4:0] MSDSPI_ADDR_STATUS3 = 5'h07;
  localparam int MSDSPI_NUM_CTRL = 3;
  localparam int MSDSPI_NUM_STAT = 4;
  localparam int MSDSPI_STAT_BITS = 7;
  localparam logic [7:0] MSDSPI_CTRL_RESET = 8'h00;
  localparam logic [6:0] MSDSPI_STAT_RESET = 7'h00;
  localparam logic [7:0] MSDSPI_PFC_WMASK = 8'hF0;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int MSDSPI_STEP_RES_HI = 7;
  localparam int MSDSPI_STEP_RES_LO = 5;
  localparam int MSDSPI_CUR_HI = 4;
  localparam int MSDSPI_CUR_LO = 0;
  localparam int MSDSPI_ROT_SENSE = 7;
  localparam int MSDSPI_STEP_EDGE_POL = 6;
  localparam int MSDSPI_PWM_RATE = 5;
  localparam int MSDSPI_PWM_JITTER = 4;
  localparam int MSDSPI_SLOPE_HI = 1;
  localparam int MSDSPI_SLOPE_LO = 0;
  localparam int MSDSPI_DRV_EN = 7;
  localparam int MSDSPI_LOW_PWR = 6;
  localparam int MSDSPI_BEMF_DIV = 5;
  localparam int MSDSPI_BEMF_TRANSP = 4;

  // ***************************************************
  // transfer counts
  // ***************************************************
  localparam logic [2:0] MSDSPI_BYTE_LAST_BIT = 3'h7;
  localparam logic [4:0] MSDSPI_WRITE_BITS = 5'h10;
  localparam logic [4:0] MSDSPI_CMD_BITS = 5'h08;
  localparam logic [4:0] MSDSPI_BITS_MAX = 5'h1F;

endpackage

// [rtl/msdspi_slave.sv]
// serial slave port of a stepper motor driver: command decode, registers, status
`timescale 1ns/1ns

// How it works
// - read command byte loads addressed register into shifter at eighth falling edge
// - next byte shifts that value out; incoming byte is next command
// - status bytes carry seven bits plus odd-count parity in bit seven
// - control registers read the same way, no parity bit
// - successive reads accepted with chip select held low
// - status contents cleared once read out
// - status and fault output update only while chip select high
// - write data stored into control register on chip select rising
// - after packets of whole bytes, every byte shifts out register at most recently received address
// - write exactly sixteen bits from its command byte to deselect, otherwise discarded whole
// - writes to read-only addresses change nothing
// - first byte after reset comes from an unknown address
// - during write data byte, old register content shifts out
// - read after write returns old value once, new value next
// - three eight-bit control registers, reset to zero
// - first byte: three-bit command then five-bit address; 000 read, 100 write
// - clock idles low, drive on falling edge, sample on rising
// - bytes travel most significant bit first
// - open-drain fault output low while any status flag set
module msdspi_slave (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial link pins
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic serial_in_pin,
  output logic serial_out_o,
  output logic serial_out_oe,
  // fault pin, open drain
  output logic fault_n_o,
  output logic fault_n_oe,
  // raw detector flags, one group per status register
  input wire logic [6:0] status_src0,
  input wire logic [6:0] status_src1,
  input wire logic [6:0] status_src2,
  input wire logic [6:0] status_src3,
  // control fields
  output logic [2:0] step_resolution,
  output logic [4:0] coil_current_level,
  output logic rotation_sense,
  output logic step_edge_polarity,
  output logic pwm_rate_select,
  output logic pwm_jitter_enable,
  output logic [1:0] slope_setting,
  output logic driver_enable,
  output logic low_power_request,
  output logic backemf_divider_select,
  output logic backemf_transparency
);

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_p;
    logic cs_s1;
    logic cs_s2;
    logic cs_p;
    logic di_s1;
    logic di_s2;
    logic [3:0][6:0] src_s1;
    logic [3:0][6:0] src_s2;
    logic [7:0] rx;
    logic [2:0] bit_cnt;
    logic byte_rdy;
    logic [7:0] tx;
    logic [4:0] addr;
    logic expect_data;
    logic wr_act;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [4:0] wr_bits;
    logic [2:0][7:0] ctrl;
    logic [3:0][6:0] stat;
    logic [3:0] clr;
    logic fault;
    logic oe;
  } msdspi_state_t;

  msdspi_state_t s_q;
  msdspi_state_t s_d;

  // ***************************************************
  // helpers
  // ***************************************************
  function automatic logic is_ctrl(input logic [4:0] a);
    is_ctrl = (a >= msdspi_pkg::MSDSPI_ADDR_STEP_CURRENT_CONFIG) &&
              (a <= msdspi_pkg::MSDSPI_ADDR_POWER_FEEDBACK_CONFIG);
  endfunction

  function automatic logic is_stat(input logic [4:0] a);
    is_stat = (a >= msdspi_pkg::MSDSPI_ADDR_STATUS0) &&
              (a <= msdspi_pkg::MSDSPI_ADDR_STATUS3);
  endfunction

  // bank index of a control address
  function automatic logic [1:0] ctrl_index(input logic [4:0] a);
    logic [4:0] diff;
    diff = a - msdspi_pkg::MSDSPI_ADDR_STEP_CURRENT_CONFIG;
    ctrl_index = diff[1:0];
  endfunction

  // bank index of a status address
  function automatic logic [1:0] stat_index(input logic [4:0] a);
    logic [4:0] diff;
    diff = a - msdspi_pkg::MSDSPI_ADDR_STATUS0;
    stat_index = diff[1:0];
  endfunction

  // command field of a first byte
  function automatic logic [2:0] cmd_field(input logic [7:0] b);
    cmd_field = b[msdspi_pkg::MSDSPI_CMD_HI:msdspi_pkg::MSDSPI_CMD_LO];
  endfunction

  // one when an odd number of bits are set
  function automatic logic odd_parity(input logic [6:0] v);
    odd_parity = ^v;
  endfunction

  // register contents as seen by the shifter
  function automatic logic [7:0] reg_value(input msdspi_state_t s, input logic [4:0] a);
    reg_value = 8'h00;
    if (is_ctrl(a)) begin
      reg_value = s.ctrl[ctrl_index(a)];
    end else if (is_stat(a)) begin
      reg_value = {odd_parity(s.stat[stat_index(a)]), s.stat[stat_index(a)]};
    end
  endfunction

  // ***************************************************
  // next state
  // ***************************************************
  always_comb begin
    logic rise;
    logic fall;
    logic cs_high;
    logic cs_rise;
    logic [7:0] rx_byte;
    logic [4:0] a;
    logic [6:0] st;
    logic any_fault;
    rise = 1'b0;
    fall = 1'b0;
    cs_high = 1'b0;
    cs_rise = 1'b0;
    rx_byte = 8'h00;
    a = 5'h00;
    st = 7'h00;
    any_fault = 1'b0;
    s_d = s_q;

    // pin synchronisers
    s_d.sclk_s1 = link_clk;
    s_d.sclk_s2 = s_q.sclk_s1;
    s_d.sclk_p = s_q.sclk_s2;
    s_d.cs_s1 = chip_select_n;
    s_d.cs_s2 = s_q.cs_s1;
    s_d.cs_p = s_q.cs_s2;
    s_d.di_s1 = serial_in_pin;
    s_d.di_s2 = s_q.di_s1;
    s_d.src_s1 = {status_src3, status_src2, status_src1, status_src0};
    s_d.src_s2 = s_q.src_s1;

    rise = s_q.sclk_s2 && !s_q.sclk_p;
    fall = !s_q.sclk_s2 && s_q.sclk_p;
    cs_high = s_q.cs_s2;
    cs_rise = s_q.cs_s2 && !s_q.cs_p;
    s_d.oe = !s_q.cs_s2;

    if (!cs_high) begin
      if (rise) begin
        s_d.rx = {s_q.rx[6:0], s_q.di_s2};
        s_d.bit_cnt = s_q.bit_cnt + 3'h1;
        s_d.byte_rdy = (s_q.bit_cnt == msdspi_pkg::MSDSPI_BYTE_LAST_BIT);
        if (s_q.wr_act && s_q.wr_bits != msdspi_pkg::MSDSPI_BITS_MAX) begin
          s_d.wr_bits = s_q.wr_bits + 5'h01;
        end
      end else if (fall) begin
        if (s_q.byte_rdy) begin
          s_d.byte_rdy = 1'b0;
          rx_byte = s_q.rx;
          if (s_q.expect_data) begin
            s_d.expect_data = 1'b0;
            s_d.wr_data = rx_byte;
            // shifter reloads from last address, old content
            s_d.tx = reg_value(s_q, s_q.addr);
          end else begin
            a = rx_byte[msdspi_pkg::MSDSPI_ADDR_HI:msdspi_pkg::MSDSPI_ADDR_LO];
            s_d.addr = a;
            s_d.tx = reg_value(s_q, a);
            if (cmd_field(rx_byte) == msdspi_pkg::MSDSPI_CMD_READ) begin
              if (is_stat(a)) begin
                s_d.clr[stat_index(a)] = 1'b1;
              end
            end else if (cmd_field(rx_byte) == msdspi_pkg::MSDSPI_CMD_WRITE) begin
              s_d.expect_data = 1'b1;
              s_d.wr_act = 1'b1;
              s_d.wr_addr = a;
              s_d.wr_bits = msdspi_pkg::MSDSPI_CMD_BITS;
            end
          end
        end else begin
          s_d.tx = {s_q.tx[6:0], 1'b0};
        end
      end
    end else begin
      s_d.bit_cnt = 3'h0;
      s_d.byte_rdy = 1'b0;
      s_d.expect_data = 1'b0;
      s_d.wr_act = 1'b0;
      s_d.wr_bits = 5'h00;
    end

    if (cs_rise && s_q.wr_act && s_q.wr_bits == msdspi_pkg::MSDSPI_WRITE_BITS &&
        is_ctrl(s_q.wr_addr)) begin
      if (s_q.wr_addr == msdspi_pkg::MSDSPI_ADDR_POWER_FEEDBACK_CONFIG) begin
        s_d.ctrl[ctrl_index(s_q.wr_addr)] = s_q.wr_data & msdspi_pkg::MSDSPI_PFC_WMASK;
      end else begin
        s_d.ctrl[ctrl_index(s_q.wr_addr)] = s_q.wr_data;
      end
    end

    // status and fault frozen while selected
    if (cs_high) begin
      for (int i = 0; i < msdspi_pkg::MSDSPI_NUM_STAT; i++) begin
        // clear after read, new events win
        st = (s_q.clr[i] ? msdspi_pkg::MSDSPI_STAT_RESET : s_q.stat[i]) | s_q.src_s2[i];
        s_d.stat[i] = st;
        any_fault = any_fault | (|st);
      end
      s_d.clr = 4'h0;
      s_d.fault = any_fault;
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // controls zero, address unknown to master
      s_q <= '0;
      s_q.sclk_s1 <= 1'b0;
      s_q.cs_s1 <= 1'b1;
      s_q.cs_s2 <= 1'b1;
      s_q.cs_p <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign serial_out_o = s_q.tx[7];
  assign serial_out_oe = s_q.oe;
  assign fault_n_o = 1'b0;
  assign fault_n_oe = s_q.fault;

  // step and current register
  assign step_resolution =
    s_q.ctrl[0][msdspi_pkg::MSDSPI_STEP_RES_HI:msdspi_pkg::MSDSPI_STEP_RES_LO];
  assign coil_current_level = s_q.ctrl[0][msdspi_pkg::MSDSPI_CUR_HI:msdspi_pkg::MSDSPI_CUR_LO];

  // drive control register
  assign rotation_sense = s_q.ctrl[1][msdspi_pkg::MSDSPI_ROT_SENSE];
  assign step_edge_polarity = s_q.ctrl[1][msdspi_pkg::MSDSPI_STEP_EDGE_POL];
  assign pwm_rate_select = s_q.ctrl[1][msdspi_pkg::MSDSPI_PWM_RATE];
  assign pwm_jitter_enable = s_q.ctrl[1][msdspi_pkg::MSDSPI_PWM_JITTER];
  assign slope_setting = s_q.ctrl[1][msdspi_pkg::MSDSPI_SLOPE_HI:msdspi_pkg::MSDSPI_SLOPE_LO];

  // power and feedback register
  assign driver_enable = s_q.ctrl[2][msdspi_pkg::MSDSPI_DRV_EN];
  assign low_power_request = s_q.ctrl[2][msdspi_pkg::MSDSPI_LOW_PWR];
  assign backemf_divider_select = s_q.ctrl[2][msdspi_pkg::MSDSPI_BEMF_DIV];
  assign backemf_transparency = s_q.ctrl[2][msdspi_pkg::MSDSPI_BEMF_TRANSP];

endmodule

// [tb/msdspi_master.sv]
// serial master model for the motor driver port
`timescale 1ns/1ns
module msdspi_master (
  // link pins
  output logic link_clk,
  output logic chip_select_n,
  output logic serial_in_pin,
  input wire logic serial_out_o,
  input wire logic serial_out_oe
);
  logic sdo;
  // pull-up while released
  assign sdo = serial_out_oe ? serial_out_o : 1'b1;
  initial begin
    link_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in_pin = 1'b0;
  end
  task automatic pkt(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    chip_select_n = 1'b0;
    #400;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_pin = tx[i];
      #400;
      link_clk = 1'b1;
      rx = {rx[30:0], sdo};
      #400;
      link_clk = 1'b0;
    end
    #400;
    chip_select_n = 1'b1;
    serial_in_pin = ~serial_in_pin;
    #1200;
  endtask
endmodule

// [tb/msdspi_slave_properties.sv]
// concurrent checks on the motor driver serial port
`timescale 1ns/1ns
module msdspi_slave_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link and fault pins
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic serial_out_o,
  input wire logic serial_out_oe,
  input wire logic fault_n_o,
  input wire logic fault_n_oe,
  // flags
  input wire logic [6:0] status_src0,
  input wire logic [6:0] status_src1,
  input wire logic [6:0] status_src2,
  input wire logic [6:0] status_src3,
  // controls
  input wire logic [2:0] step_resolution,
  input wire logic [4:0] coil_current_level,
  input wire logic rotation_sense,
  input wire logic step_edge_polarity,
  input wire logic pwm_rate_select,
  input wire logic pwm_jitter_enable,
  input wire logic [1:0] slope_setting,
  input wire logic driver_enable,
  input wire logic low_power_request,
  input wire logic backemf_divider_select,
  input wire logic backemf_transparency
);
  logic [17:0] ctl;
  logic flag;
  assign ctl = {step_resolution, coil_current_level, rotation_sense, step_edge_polarity,
    pwm_rate_select, pwm_jitter_enable, slope_setting, driver_enable, low_power_request,
    backemf_divider_select, backemf_transparency};
  assign flag = |{status_src0, status_src1, status_src2, status_src3};
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_oe_on_select: assert property (!chip_select_n [*5] |-> serial_out_oe)
    else $error("output not driven while selected");
  a_oe_off_desel: assert property ($rose(chip_select_n) |-> ##[1:5] !serial_out_oe)
    else $error("output still driven after deselect");
  a_out_hold_high: assert property (link_clk [*4] |-> $stable(serial_out_o))
    else $error("output moved while link clock high");
  a_fault_frozen: assert property (!chip_select_n [*6] |-> $stable(fault_n_oe))
    else $error("fault moved while selected");
  a_fault_on_flag: assert property ((flag && chip_select_n) [*6] |-> fault_n_oe)
    else $error("fault not raised for flag");
  a_fault_drain: assert property (fault_n_o == 1'b0)
    else $error("fault pin drives high");
  a_ctl_frozen: assert property (!chip_select_n [*6] |-> $stable(ctl))
    else $error("control changed while selected");
  a_ctl_on_rise: assert property ($changed(ctl) && !$past(rst) |-> chip_select_n)
    else $error("control changed outside deselect");
  a_ctl_reset: assert property (disable iff (1'b0) rst |=> ctl == 18'h0)
    else $error("control not cleared by reset");
  c_fault: cover property ($rose(fault_n_oe));
  c_ctl: cover property ($changed(ctl));
  c_chain: cover property (!chip_select_n [*8]);
endmodule
bind msdspi_slave msdspi_slave_properties i_msdspi_slave_properties (.core_clk, .rst,
  .link_clk, .chip_select_n, .serial_out_o, .serial_out_oe, .fault_n_o, .fault_n_oe,
  .status_src0, .status_src1, .status_src2, .status_src3, .step_resolution,
  .coil_current_level, .rotation_sense, .step_edge_polarity, .pwm_rate_select,
  .pwm_jitter_enable, .slope_setting, .driver_enable, .low_power_request,
  .backemf_divider_select, .backemf_transparency);

// [tb/test_msdspi_slave.sv]
// self-checking bench for the motor driver serial port
`timescale 1ns/1ns
module test_msdspi_slave;
  localparam logic [2:0] RD = msdspi_pkg::MSDSPI_CMD_READ;
  localparam logic [2:0] WR = msdspi_pkg::MSDSPI_CMD_WRITE;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic link_clk, chip_select_n, serial_in_pin, serial_out_o, serial_out_oe;
  logic fault_n_o, fault_n_oe, rotation_sense, step_edge_polarity, pwm_rate_select;
  logic pwm_jitter_enable, driver_enable, low_power_request;
  logic backemf_divider_select, backemf_transparency;
  logic [6:0] status_src0 = 7'h00, status_src1 = 7'h00;
  logic [6:0] status_src2 = 7'h00, status_src3 = 7'h00;
  logic [2:0] step_resolution;
  logic [4:0] coil_current_level;
  logic [1:0] slope_setting;
  logic [7:0] c1, c2, c3;
  logic [31:0] rx;
  int failures = 0;
  int n_tests = 0;
  assign c1 = {step_resolution, coil_current_level};
  assign c2 = {rotation_sense, step_edge_polarity, pwm_rate_select, pwm_jitter_enable,
    2'h0, slope_setting};
  assign c3 = {driver_enable, low_power_request, backemf_divider_select,
    backemf_transparency, 4'h0};
  always #50 core_clk = ~core_clk;
  msdspi_slave i_msdspi_slave (.core_clk, .rst, .link_clk, .chip_select_n,
    .serial_in_pin, .serial_out_o, .serial_out_oe, .fault_n_o, .fault_n_oe,
    .status_src0, .status_src1, .status_src2, .status_src3, .step_resolution,
    .coil_current_level, .rotation_sense, .step_edge_polarity, .pwm_rate_select,
    .pwm_jitter_enable, .slope_setting, .driver_enable, .low_power_request,
    .backemf_divider_select, .backemf_transparency);
  msdspi_master i_msdspi_master (.link_clk, .chip_select_n, .serial_in_pin,
    .serial_out_o, .serial_out_oe);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ***************************************************
  // scenarios
  // ***************************************************
  // first byte out is from an unknown address, never compared
  task automatic t_reset();
    i_msdspi_master.pkt(32, {RD, 5'h01, RD, 5'h02, RD, 5'h03, 8'h00}, rx);
    chk(rx[23:16], 8'h00);
    chk(rx[15:8], 8'h00);
    chk(rx[7:0], 8'h00);
  endtask
  task automatic t_write();
    i_msdspi_master.pkt(16, {WR, 5'h01, 8'hA5}, rx);
    chk(rx[7:0], 8'h00);
    chk(c1, 8'hA5);
    i_msdspi_master.pkt(16, {RD, 5'h01, 8'h00}, rx);
    chk(rx[15:8], 8'h00);
    chk(rx[7:0], 8'hA5);
  endtask
  task automatic t_write_all();
    i_msdspi_master.pkt(16, {WR, 5'h02, 8'hFF}, rx);
    i_msdspi_master.pkt(16, {WR, 5'h03, 8'hFF}, rx);
    chk(c2, 8'hF3);
    chk(c3, 8'hF0);
    i_msdspi_master.pkt(24, {RD, 5'h03, RD, 5'h02, 8'h00}, rx);
    chk(rx[15:8], 8'hF0);
    chk(rx[7:0], 8'hFF);
  endtask
  task automatic t_bad_len();
    i_msdspi_master.pkt(15, {WR, 5'h01, 7'h3C}, rx);
    chk(c1, 8'hA5);
    i_msdspi_master.pkt(17, {WR, 5'h01, 8'h3C, 1'b0}, rx);
    chk(c1, 8'hA5);
    i_msdspi_master.pkt(16, {WR, 5'h04, 8'h3C}, rx);
    chk(c1, 8'hA5);
    chk({7'h0, fault_n_oe}, 8'h00);
  endtask
  task automatic t_status();
    status_src1 = 7'h07;
    status_src2 = 7'h03;
    repeat (8) @(negedge core_clk);
    chk({7'h0, fault_n_oe}, 8'h01);
    status_src1 = 7'h00;
    status_src2 = 7'h00;
    repeat (8) @(negedge core_clk);
    i_msdspi_master.pkt(24, {RD, 5'h05, RD, 5'h06, 8'h00}, rx);
    chk(rx[15:8], 8'h87);
    chk(rx[7:0], 8'h03);
    chk({7'h0, fault_n_oe}, 8'h00);
    i_msdspi_master.pkt(16, {RD, 5'h05, 8'h00}, rx);
    chk(rx[7:0], 8'h00);
  endtask
  // flag raised mid-packet stays out of status until deselect
  task automatic t_freeze();
    fork
      i_msdspi_master.pkt(16, {RD, 5'h04, 8'h00}, rx);
      begin
        #1000;
        status_src0 = 7'h01;
      end
    join
    chk(rx[7:0], 8'h00);
    chk({7'h0, fault_n_oe}, 8'h01);
    status_src0 = 7'h00;
    i_msdspi_master.pkt(16, {RD, 5'h04, 8'h00}, rx);
    chk(rx[7:0], 8'h81);
    chk({7'h0, fault_n_oe}, 8'h00);
  endtask
  task automatic end_of_test();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_write();
    t_write_all();
    t_bad_len();
    t_status();
    t_freeze();
    end_of_test();
  end
  initial begin
    #2000000;
    failures++;
    end_of_test();
  end
endmodule
